// File: rtl/cac_consts.vh
// constants for the calendar alarm and calibration block
// How it works
// (R1) each second update compares unmasked alarm fields with time; full agreement is an event
// (R2) mask field at config bits 13:10 picks which time fields take part
// (R3) mask 0110 compares hours, minutes and seconds only: once a day
// (R4) events only while the alarm enable bit is set
// (R5) repeat-forever clear and count zero: enable clears on the first event
// (R6) repeat-forever clear: count decrements per event, enable clears once it is zero
// (R7) repeat-forever set: events continue, count still decrements, enable stays
// (R8) each event can raise the interrupt and, separately, toggle the output pin
// (R9) interrupt only with irq enable set and a non-zero 3-bit priority
// (R10) select 0: pin toggles per event; select 1: pin carries 1 Hz clock
// (R11) software clears alarm enable before writing alarm value fields
// (R12) alarm value fields are readable at any time
// (R13) once a minute the signed 8-bit calibration value adjusts the prescaler
// (R14) each calibration unit adds or removes four oscillator cycles per minute
// (R15) adjustment lands on the 512th oscillator edge after seconds roll 59 to 00
// (R16) 2-bit window pointer: 00 min/sec, 01 weekday/hours, 10 month/day
// (R17) config: enable 15, repeat-forever 14, mask 13:10, pointer 9:8, count 7:0
// (R18) pointer decrements after each window access, holding at zero
`ifndef CAC_CONSTS_VH
`define CAC_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define CAC_ADDR_ALARM_CONFIG 3'h0
`define CAC_ADDR_ALARM_WINDOW 3'h1
`define CAC_ADDR_CLOCK_CONFIG 3'h2
`define CAC_ADDR_PAD_CONFIG 3'h3
`define CAC_ADDR_IRQ_CONFIG 3'h4
`define CAC_ADDR_IRQ_STATUS 3'h5
`define CAC_ADDR_IRQ_MASK 3'h6

// ****************************************
// field positions
// ****************************************
`define CAC_ALM_ENABLE_BIT 15
`define CAC_ALM_CHIME_BIT 14
`define CAC_ALM_MASK_HI 13
`define CAC_ALM_MASK_LO 10
`define CAC_ALM_PTR_HI 9
`define CAC_ALM_PTR_LO 8
`define CAC_CLK_HALF_SECOND_BIT 11
`define CAC_CLK_PIN_OE_BIT 10
`define CAC_PAD_SELECT_BIT 1
`define CAC_IRQ_ENABLE_BIT 15
`define CAC_STAT_ALARM_BIT 0
`define CAC_STAT_SECOND_BIT 1

// ****************************************
// field masks, window pointers, mask codes
// ****************************************
`define CAC_WIN_MIN_SEC_MASK 16'h7f7f
`define CAC_WIN_WDAY_HR_MASK 16'h073f
`define CAC_WIN_MON_DAY_MASK 16'h1f3f
`define CAC_PTR_MIN_SEC 2'h0
`define CAC_PTR_WDAY_HR 2'h1
`define CAC_PTR_MON_DAY 2'h2
`define CAC_FMASK_SEC_ONES 4'h2
`define CAC_FMASK_SEC 4'h3
`define CAC_FMASK_MIN_ONES 4'h4
`define CAC_FMASK_MIN 4'h5
`define CAC_FMASK_DAY 4'h6
`define CAC_FMASK_WEEK 4'h7
`define CAC_FMASK_MONTH 4'h8
`define CAC_FMASK_YEAR 4'h9
`define CAC_FMASK_LAST_ANY 4'h1

// ****************************************
// reset values and timing
// ****************************************
`define CAC_RESET_WORD 16'h0000
`define CAC_PRESCALE_TOP 15'h7fff
`define CAC_CAL_POINT 10'h200
`define CAC_CAL_STEP_SHIFT 2

`endif

// File: rtl/cac_match.v
// alarm field comparator for the calendar alarm block
`timescale 1ns/100ps
module cac_match (
    // mask code
    input wire [3:0] alarm_field_mask,
    // alarm fields
    input wire [15:0] alm_min_sec,
    input wire [15:0] alm_wday_hr,
    input wire [15:0] alm_mon_day,
    // time fields
    input wire [15:0] time_min_sec,
    input wire [15:0] time_wday_hr,
    input wire [15:0] time_mon_day,
    // result
    output reg match
);
`include "cac_consts.vh"

    wire sec_ones_eq;
    wire sec_eq;
    wire min_ones_eq;
    wire min_eq;
    wire hr_eq;
    wire wday_eq;
    wire day_eq;
    wire mon_eq;

    assign sec_ones_eq = (alm_min_sec[3:0] == time_min_sec[3:0]);
    assign sec_eq = (alm_min_sec[6:0] == time_min_sec[6:0]);
    assign min_ones_eq = (alm_min_sec[11:8] == time_min_sec[11:8]);
    assign min_eq = (alm_min_sec[14:8] == time_min_sec[14:8]);
    assign hr_eq = (alm_wday_hr[5:0] == time_wday_hr[5:0]);
    assign wday_eq = (alm_wday_hr[10:8] == time_wday_hr[10:8]);
    assign day_eq = (alm_mon_day[5:0] == time_mon_day[5:0]);
    assign mon_eq = (alm_mon_day[12:8] == time_mon_day[12:8]);

    // deeper codes take in more fields, except month, which swaps weekday for day; codes above year never fire
    always @* begin
        case (alarm_field_mask)
            `CAC_FMASK_SEC_ONES: match = sec_ones_eq; // see (R2)
            `CAC_FMASK_SEC: match = sec_eq;
            `CAC_FMASK_MIN_ONES: match = sec_eq & min_ones_eq;
            `CAC_FMASK_MIN: match = sec_eq & min_eq;
            `CAC_FMASK_DAY: match = sec_eq & min_eq & hr_eq; // see (R3)
            `CAC_FMASK_WEEK: match = sec_eq & min_eq & hr_eq & wday_eq;
            `CAC_FMASK_MONTH: match = sec_eq & min_eq & hr_eq & day_eq;
            `CAC_FMASK_YEAR: match = sec_eq & min_eq & hr_eq & day_eq & mon_eq;
            default: match = (alarm_field_mask <= `CAC_FMASK_LAST_ANY);
        endcase
    end
endmodule

// File: rtl/cac_top.v
// alarm, pin output and calibration logic of the calendar clock
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "cac_consts.vh"
module cac_top #(
    parameter [14:0] PRESCALE_TOP = `CAC_PRESCALE_TOP,
    parameter [9:0] CAL_POINT = `CAC_CAL_POINT
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // oscillator edge, one cycle per 32.768 kHz edge
    input wire osc_tick,
    // current time from the external counters
    input wire [15:0] time_min_sec,
    input wire [15:0] time_wday_hr,
    input wire [15:0] time_mon_day,
    // register port
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // second update to the time counters
    output reg sec_tick,
    // pin and interrupt
    output reg pin_out,
    output reg pin_oe,
    output reg alarm_irq
);

    // ****************************************
    // state
    // ****************************************
    reg alarm_enable_bit_reg;
    reg chime_reg;
    reg [3:0] alarm_field_mask_reg;
    reg [1:0] alarm_window_pointer_reg;
    reg [7:0] alarm_repeat_count_reg;
    reg [15:0] alm_min_sec_reg;
    reg [15:0] alm_wday_hr_reg;
    reg [15:0] alm_mon_day_reg;
    reg [7:0] cal_value_reg;
    reg pin_enable_reg;
    reg pin_output_select_reg;
    reg alarm_irq_enable_reg;
    reg [2:0] alarm_irq_priority_reg;
    reg [1:0] status_reg;
    reg [1:0] irq_mask_reg;
    reg [14:0] prescale_reg;
    reg compare_reg;
    reg cal_run_reg;
    reg [9:0] cal_count_reg;
    reg toggle_reg;

    reg [15:0] rdata_next;
    reg [1:0] status_next;
    reg [14:0] prescale_next;

    wire match;
    wire alarm_event;
    wire cfg_wr;
    wire win_wr;
    wire win_access;
    wire half_second_flag;
    wire cal_apply;
    wire [14:0] cal_ext;
    wire [14:0] cal_adjust;
    wire [15:0] alarm_config_word;
    wire [15:0] window_word;

    // ****************************************
    // comparator
    // ****************************************
    cac_match u_match (
        .alarm_field_mask(alarm_field_mask_reg),
        .alm_min_sec(alm_min_sec_reg),
        .alm_wday_hr(alm_wday_hr_reg),
        .alm_mon_day(alm_mon_day_reg),
        .time_min_sec(time_min_sec),
        .time_wday_hr(time_wday_hr),
        .time_mon_day(time_mon_day),
        .match(match)
    );

    // counters take the new second on sec_tick; compare the cycle after
    assign alarm_event = compare_reg & match & alarm_enable_bit_reg; // see (R1) see (R4)

    // ****************************************
    // register decode
    // ****************************************
    assign cfg_wr = reg_wr & (reg_addr == `CAC_ADDR_ALARM_CONFIG);
    assign win_wr = reg_wr & (reg_addr == `CAC_ADDR_ALARM_WINDOW);
    assign win_access = (reg_wr | reg_rd) & (reg_addr == `CAC_ADDR_ALARM_WINDOW);

    assign alarm_config_word = {alarm_enable_bit_reg, chime_reg, alarm_field_mask_reg,
                                alarm_window_pointer_reg, alarm_repeat_count_reg}; // see (R17)

    assign window_word = (alarm_window_pointer_reg == `CAC_PTR_MIN_SEC) ? alm_min_sec_reg :
                         (alarm_window_pointer_reg == `CAC_PTR_WDAY_HR) ? alm_wday_hr_reg :
                         (alarm_window_pointer_reg == `CAC_PTR_MON_DAY) ? alm_mon_day_reg :
                         `CAC_RESET_WORD; // see (R16)

    // ****************************************
    // alarm configuration and repeat
    // ****************************************
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_enable_bit_reg <= 1'b0;
            chime_reg <= 1'b0;
            alarm_field_mask_reg <= 4'h0;
            alarm_window_pointer_reg <= 2'h0;
            alarm_repeat_count_reg <= 8'h00;
        end else if (cfg_wr) begin
            // software write wins over a coincident event
            alarm_enable_bit_reg <= reg_wdata[`CAC_ALM_ENABLE_BIT];
            chime_reg <= reg_wdata[`CAC_ALM_CHIME_BIT];
            alarm_field_mask_reg <= reg_wdata[`CAC_ALM_MASK_HI:`CAC_ALM_MASK_LO]; // see (R2)
            alarm_window_pointer_reg <= reg_wdata[`CAC_ALM_PTR_HI:`CAC_ALM_PTR_LO];
            alarm_repeat_count_reg <= reg_wdata[7:0];
        end else begin
            if (win_access && alarm_window_pointer_reg != 2'h0) begin
                alarm_window_pointer_reg <= alarm_window_pointer_reg - 2'h1; // see (R18)
            end
            if (alarm_event) begin
                if (chime_reg) begin
                    alarm_repeat_count_reg <= alarm_repeat_count_reg - 8'h01; // see (R7)
                end else if (alarm_repeat_count_reg == 8'h00) begin
                    alarm_enable_bit_reg <= 1'b0; // see (R5) see (R6)
                end else begin
                    alarm_repeat_count_reg <= alarm_repeat_count_reg - 8'h01; // see (R6)
                end
            end
        end
    end

    // ****************************************
    // alarm value window
    // ****************************************
    // writes with the alarm enabled are taken; a false match is the caller's hazard
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alm_min_sec_reg <= `CAC_RESET_WORD;
            alm_wday_hr_reg <= `CAC_RESET_WORD;
            alm_mon_day_reg <= `CAC_RESET_WORD;
        end else if (win_wr) begin
            case (alarm_window_pointer_reg)
                `CAC_PTR_MIN_SEC: alm_min_sec_reg <= reg_wdata & `CAC_WIN_MIN_SEC_MASK;
                `CAC_PTR_WDAY_HR: alm_wday_hr_reg <= reg_wdata & `CAC_WIN_WDAY_HR_MASK;
                `CAC_PTR_MON_DAY: alm_mon_day_reg <= reg_wdata & `CAC_WIN_MON_DAY_MASK;
                default: alm_min_sec_reg <= alm_min_sec_reg;
            endcase
        end
    end

    // ****************************************
    // clock, pad and interrupt configuration
    // ****************************************
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_value_reg <= 8'h00;
            pin_enable_reg <= 1'b0;
            pin_output_select_reg <= 1'b0;
            alarm_irq_enable_reg <= 1'b0;
            alarm_irq_priority_reg <= 3'h0;
            irq_mask_reg <= 2'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `CAC_ADDR_CLOCK_CONFIG: begin
                    cal_value_reg <= reg_wdata[7:0];
                    pin_enable_reg <= reg_wdata[`CAC_CLK_PIN_OE_BIT];
                end
                `CAC_ADDR_PAD_CONFIG: begin
                    pin_output_select_reg <= reg_wdata[`CAC_PAD_SELECT_BIT];
                end
                `CAC_ADDR_IRQ_CONFIG: begin
                    alarm_irq_enable_reg <= reg_wdata[`CAC_IRQ_ENABLE_BIT];
                    alarm_irq_priority_reg <= reg_wdata[2:0];
                end
                `CAC_ADDR_IRQ_MASK: begin
                    irq_mask_reg <= reg_wdata[1:0];
                end
                default: begin
                    irq_mask_reg <= irq_mask_reg;
                end
            endcase
        end
    end

    // ****************************************
    // sticky status, write one to clear
    // ****************************************
    always @* begin
        status_next = status_reg;
        if (reg_wr && reg_addr == `CAC_ADDR_IRQ_STATUS) begin
            status_next = status_reg & ~reg_wdata[1:0];
        end
        // a new event beats a clear in the same cycle
        if (alarm_event) begin
            status_next[`CAC_STAT_ALARM_BIT] = 1'b1; // see (R8)
        end
        if (sec_tick) begin
            status_next[`CAC_STAT_SECOND_BIT] = 1'b1;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= 2'h0;
            alarm_irq <= 1'b0;
        end else begin
            status_reg <= status_next;
            alarm_irq <= alarm_irq_enable_reg & (alarm_irq_priority_reg != 3'h0) &
                         (|(status_next & irq_mask_reg)); // see (R9) see (R8)
        end
    end

    // ****************************************
    // prescaler and calibration
    // ****************************************
    assign half_second_flag = (prescale_reg > (PRESCALE_TOP >> 1));
    assign cal_ext = {{7{cal_value_reg[7]}}, cal_value_reg};
    assign cal_adjust = {cal_ext[12:0], 2'b00}; // see (R14)
    assign cal_apply = cal_run_reg & osc_tick & (cal_count_reg == CAL_POINT - 10'h001); // see (R15)

    // adjust lands 512 counts into the second, so a step of up to 512 counts cannot wrap
    always @* begin
        prescale_next = prescale_reg;
        if (osc_tick) begin
            if (prescale_reg == PRESCALE_TOP) begin
                prescale_next = 15'h0000;
            end else if (cal_apply) begin
                prescale_next = prescale_reg + 15'h0001 + cal_adjust; // see (R13)
            end else begin
                prescale_next = prescale_reg + 15'h0001;
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale_reg <= 15'h0000;
            sec_tick <= 1'b0;
            compare_reg <= 1'b0;
            cal_run_reg <= 1'b0;
            cal_count_reg <= 10'h000;
        end else begin
            prescale_reg <= prescale_next;
            sec_tick <= osc_tick & (prescale_reg == PRESCALE_TOP);
            compare_reg <= sec_tick; // see (R1)
            if (compare_reg && time_min_sec[7:0] == 8'h00) begin
                cal_run_reg <= 1'b1; // see (R15)
                cal_count_reg <= 10'h000;
            end else if (cal_apply) begin
                cal_run_reg <= 1'b0;
            end else if (cal_run_reg && osc_tick) begin
                cal_count_reg <= cal_count_reg + 10'h001;
            end
        end
    end

    // ****************************************
    // output pin
    // ****************************************
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            toggle_reg <= 1'b0;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            if (alarm_event) begin
                toggle_reg <= ~toggle_reg; // see (R8)
            end
            pin_oe <= pin_enable_reg;
            pin_out <= pin_output_select_reg ? half_second_flag : toggle_reg; // see (R10)
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always @* begin
        rdata_next = `CAC_RESET_WORD;
        case (reg_addr)
            `CAC_ADDR_ALARM_CONFIG: rdata_next = alarm_config_word;
            `CAC_ADDR_ALARM_WINDOW: rdata_next = window_word; // see (R12)
            `CAC_ADDR_CLOCK_CONFIG: begin
                rdata_next[7:0] = cal_value_reg;
                rdata_next[`CAC_CLK_PIN_OE_BIT] = pin_enable_reg;
                rdata_next[`CAC_CLK_HALF_SECOND_BIT] = half_second_flag;
            end
            `CAC_ADDR_PAD_CONFIG: rdata_next[`CAC_PAD_SELECT_BIT] = pin_output_select_reg;
            `CAC_ADDR_IRQ_CONFIG: begin
                rdata_next[`CAC_IRQ_ENABLE_BIT] = alarm_irq_enable_reg;
                rdata_next[2:0] = alarm_irq_priority_reg;
            end
            `CAC_ADDR_IRQ_STATUS: rdata_next[1:0] = status_reg;
            `CAC_ADDR_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
            default: rdata_next = `CAC_RESET_WORD;
        endcase
    end

    // read data stand one cycle after the strobe, zero otherwise
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= `CAC_RESET_WORD;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= `CAC_RESET_WORD;
        end
    end
endmodule

// File: testbench/cac_props.sv
// port assertions for the calendar alarm block
`timescale 1ns/100ps
module cac_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // outputs
    input wire logic sec_tick,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic alarm_irq
);
    // ****
    // shadows of written settings
    // ****
    logic sel_reg;
    logic oe_reg;
    logic ok_reg;
    logic [2:0] age_reg;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_reg <= 1'b0;
            oe_reg <= 1'b0;
            ok_reg <= 1'b0;
            age_reg <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == 3'h2)
                oe_reg <= reg_wdata[10];
            if (reg_wr && reg_addr == 3'h4)
                ok_reg <= reg_wdata[15] && reg_wdata[2:0] != 3'h0;
            // toggle source checked only once the select has settled
            if (reg_wr && reg_addr == 3'h3) begin
                sel_reg <= reg_wdata[1];
                age_reg <= 3'h0;
            end else if (age_reg != 3'h7) begin
                age_reg <= age_reg + 3'h1;
            end
        end
    end
    // ****
    // properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmap; $past(reg_rd) && $past(reg_addr) == 3'h7 |-> reg_rdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_pad_rb; $past(reg_rd) && $past(reg_addr) == 3'h3 |-> reg_rdata == {14'h0, $past(sel_reg), 1'b0}; endproperty
    a_pad_rb: assert property (p_pad_rb) else $error("pad select readback");
    property p_irq_gate; alarm_irq |-> ok_reg || $past(ok_reg); endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
    property p_irq_hold; alarm_irq && !reg_wr && !$past(reg_wr) |=> alarm_irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_oe; pin_oe == oe_reg || pin_oe == $past(oe_reg); endproperty
    a_oe: assert property (p_oe) else $error("pin enable mismatch");
    property p_toggle; $changed(pin_out) && !sel_reg && age_reg == 3'h7 |-> $past(sec_tick, 3); endproperty
    a_toggle: assert property (p_toggle) else $error("pin toggled off event");
    property p_sec_gap; sec_tick |=> !sec_tick [*8]; endproperty
    a_sec_gap: assert property (p_sec_gap) else $error("second ticks too close");
endmodule

bind cac_top cac_props u_props (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sec_tick(sec_tick), .pin_out(pin_out), .pin_oe(pin_oe), .alarm_irq(alarm_irq));

// File: testbench/tb.sv
// self-checking bench of the calendar alarm block
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic osc_tick = 1'b0;
    logic [7:0] tsec = 8'h00;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] d;
    wire [15:0] reg_rdata;
    wire sec_tick;
    wire pin_out;
    wire pin_oe;
    wire alarm_irq;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;

    always #2 clk = ~clk;

    // small prescaler keeps a second at 2048 cycles
    cac_top #(.PRESCALE_TOP(15'd1023), .CAL_POINT(10'd100)) dut_u (.clk(clk),
        .reset_n(reset_n), .osc_tick(osc_tick), .time_min_sec({8'h00, tsec}),
        .time_wday_hr(16'h0106), .time_mon_day(16'h0101), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sec_tick(sec_tick), .pin_out(pin_out), .pin_oe(pin_oe), .alarm_irq(alarm_irq));

    function automatic logic [7:0] binc(input logic [7:0] v);
        if (v == 8'h59)
            return 8'h00;
        if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        return v + 8'h01;
    endfunction

    // ****
    // time counters, oscillator and watchdog
    // ****
    always @(posedge clk) begin
        osc_tick <= ~osc_tick;
        if (sec_tick)
            tsec <= binc(tsec);
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            summarize;
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rc(input logic [2:0] a, input logic [15:0] e, input string n);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        chk(n, e, d);
        @(posedge clk);
    endtask

    // returns four cycles after a second update
    task automatic wsec;
        int i;
        #1;
        for (i = 0; i < 3000 && sec_tick !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic span(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n += int'(osc_tick);
        end while (sec_tick !== 1'b1 && n < 2000);
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_regs;
        int a;
        for (a = 0; a < 8; a++)
            rc(a[2:0], 16'h0000, "reset word");
        $display("test regs done");
    endtask

    task automatic t_window;
        wr(3'h0, 16'h0200);
        wr(3'h1, 16'hff03);
        wr(3'h1, 16'hff06);
        wr(3'h1, 16'h0012);
        rc(3'h0, 16'h0000, "pointer walk");
        wr(3'h0, 16'h0200);
        rc(3'h1, 16'h1f03, "month day");
        rc(3'h1, 16'h0706, "weekday hours");
        rc(3'h1, 16'h0012, "min sec");
        rc(3'h1, 16'h0012, "pointer hold");
        $display("test window done");
    endtask

    task automatic t_oneshot;
        int i;
        wr(3'h4, 16'h8001);
        wr(3'h6, 16'h0001);
        wsec;
        tsec = 8'h09;
        wr(3'h0, 16'h9800);
        for (i = 0; i < 5 && alarm_irq !== 1'b1; i++)
            wsec;
        chk("alarm second", 16'h0012, {8'h00, tsec});
        chk("irq", 16'h0001, {15'h0, alarm_irq});
        chk("pin toggle", 16'h0001, {15'h0, pin_out});
        rc(3'h0, 16'h1800, "one shot config");
        rc(3'h5, 16'h0003, "status");
        wr(3'h5, 16'h0001);
        #1 chk("irq cleared", 16'h0000, {15'h0, alarm_irq});
        tsec = 8'h11;
        wsec;
        rc(3'h5, 16'h0002, "disabled match");
        $display("test one shot done");
    endtask

    task automatic t_repeat;
        int k;
        wr(3'h4, 16'h8000);
        wsec;
        wr(3'h0, 16'h8402);
        for (k = 0; k < 5; k++) begin
            wsec;
            rc(3'h5, (k < 3) ? 16'h0003 : 16'h0002, "repeat event");
            chk("zero priority", 16'h0000, {15'h0, alarm_irq});
            wr(3'h5, 16'h0001);
        end
        rc(3'h0, 16'h0400, "repeat done");
        chk("pin after three", 16'h0000, {15'h0, pin_out});
        $display("test repeat done");
    endtask

    task automatic t_chime;
        wr(3'h4, 16'h8001);
        wsec;
        wr(3'h0, 16'hc400);
        repeat (3) wsec;
        rc(3'h0, 16'hc4fd, "forever count");
        chk("forever irq", 16'h0001, {15'h0, alarm_irq});
        wr(3'h0, 16'h0000);
        wr(3'h5, 16'h0001);
        $display("test chime done");
    endtask

    // the adjusted second differs from a plain one by four ticks per unit
    task automatic t_cal;
        int n0;
        int n1;
        int c;
        for (c = 2; c >= -2; c -= 4) begin
            wr(3'h2, 16'(c) & 16'h00ff);
            wsec;
            tsec = 8'h58;
            span(n0);
            span(n0);
            span(n1);
            chk("cal span", 16'(n0 - 4 * c), 16'(n1));
        end
        $display("test calibration done");
    endtask

    task automatic t_secpin;
        int r;
        logic p;
        r = 0;
        wr(3'h2, 16'h0400);
        wr(3'h3, 16'h0002);
        rc(3'h3, 16'h0002, "pad select");
        #1 p = pin_out;
        repeat (4096) begin
            @(posedge clk);
            #1 r += int'(pin_out && !p);
            p = pin_out;
        end
        chk("seconds clock rises", 16'h0002, 16'(r));
        chk("pin enable", 16'h0001, {15'h0, pin_oe});
        $display("test seconds pin done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_window;
        t_oneshot;
        t_repeat;
        t_chime;
        t_cal;
        t_secpin;
        summarize;
    end
endmodule
